// ---- verilog/dlr_pkg.sv ----
package dlr_pkg;

    // ************************************************************
    // command type and subcommand codes
    // ************************************************************
    localparam logic [7:0] TY_PIXEL = 8'h00;
    localparam logic [7:0] TY_DEPTH_PIXEL = 8'h01;
    localparam logic [7:0] TY_LINE = 8'h02;
    localparam logic [7:0] TY_XY_LINE = 8'h03;
    localparam logic [7:0] TY_PXY_LINE = 8'h04;
    localparam logic [7:0] TY_TRAP = 8'h05;
    localparam logic [7:0] TY_VTX = 8'h70;
    localparam logic [7:0] TY_PVTX = 8'h71;
    localparam logic [7:0] TY_DRAW = 8'hF0;
    localparam logic [7:0] TY_REG_LOAD = 8'hF1;
    localparam logic [7:0] TY_SYNC = 8'hFC;
    localparam logic [7:0] TY_IRQ = 8'hFD;
    localparam logic [7:0] TY_NOP = 8'hFF;
    localparam logic [7:0] SUB_PIXEL_FLUSH = 8'hC1;
    localparam logic [7:0] SUB_DEPTH_FLUSH = 8'hC2;
    localparam logic [7:0] SUB_SHAPE_START = 8'hE0;
    localparam logic [7:0] SUB_SHAPE_FILL = 8'hE1;

    // ************************************************************
    // header field positions and word counts
    // ************************************************************
    localparam int HDR_TYPE_LSB = 24;
    localparam int HDR_SUB_LSB = 16;
    localparam int HDR_VERTICAL_BLANK_FLAG_BIT = 0;
    localparam logic [1:0] VTX_CODE_TRI = 2'h2;
    localparam logic [1:0] VTX_CODE_BAD = 2'h3;
    localparam logic [7:0] WORDS_PIXEL = 8'h02;
    localparam logic [7:0] WORDS_DEPTH_PIXEL = 8'h03;
    localparam logic [7:0] WORDS_LINE = 8'h05;
    localparam logic [7:0] WORDS_XY_LINE = 8'h02;
    localparam logic [7:0] WORDS_PACKED = 8'h01;
    localparam logic [7:0] WORDS_TRAP = 8'h09;
    localparam logic [7:0] WORDS_VTX = 8'h02;

    // ************************************************************
    // register map and reset values
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SYNC_BIT = 1;
    localparam int ST_ERR_VTX_BIT = 2;
    localparam int ST_ERR_TYPE_BIT = 3;
    localparam logic RUN_RST = 1'b0;

    typedef enum logic [1:0] {
        DLR_FETCH,
        DLR_PARAM,
        DLR_SYNC,
        DLR_DRAW
    } dlr_state_e;

endpackage : dlr_pkg

// ---- verilog/dlr_cmd_decoder.sv ----
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dlr_cmd_decoder (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [31:0] dl_word_i,
    input wire logic dl_valid_i,
    output logic dl_ready_o,
    input wire logic vertical_blank_flag_i,
    input wire logic raster_busy_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    output logic reg_wr_o,
    output logic [15:0] reg_addr_o,
    output logic [31:0] reg_data_o,
    output logic prm_wr_o,
    output logic [3:0] prm_idx_o,
    output logic [31:0] prm_data_o,
    output logic vtx_wr_o,
    output logic [1:0] vtx_sel_o,
    output logic [15:0] vtx_x_o,
    output logic [15:0] vtx_y_o,
    output logic [15:0] bb_xmin_o,
    output logic [15:0] bb_ymin_o,
    output logic [15:0] bb_xmax_o,
    output logic [15:0] bb_ymax_o,
    output logic draw_go_o,
    output logic [7:0] draw_type_o,
    output logic [7:0] draw_sub_o,
    output logic ln_alt_o,
    output logic ln_no_end_o,
    output logic ln_pat_clr_o,
    output logic ln_anti_o,
    output logic trap_left_o
);

    typedef struct packed {
        dlr_pkg::dlr_state_e st;
        logic ready;
        logic [7:0] typ;
        logic [7:0] sub;
        logic [1:0] vsel;
        logic [7:0] cnt;
        logic [7:0] idx;
        logic [15:0] raddr;
        logic vb1;
        logic vb2;
        logic vb3;
        logic run;
        logic err_vtx;
        logic err_type;
        logic [15:0] cmds;
        logic ahb_wr;
        logic [7:0] ahb_ofs;
        logic [31:0] rdata;
        logic reg_wr;
        logic [15:0] reg_addr;
        logic [31:0] reg_data;
        logic prm_wr;
        logic [3:0] prm_idx;
        logic [31:0] prm_data;
        logic vtx_wr;
        logic [1:0] vtx_sel;
        logic [15:0] vtx_x;
        logic [15:0] vtx_y;
        logic shape_on;
        logic bb_valid;
        logic [15:0] bb_x0;
        logic [15:0] bb_y0;
        logic [15:0] bb_x1;
        logic [15:0] bb_y1;
        logic go;
        logic [7:0] go_type;
        logic [7:0] go_sub;
        logic [3:0] go_line;
        logic go_left;
    } dlr_regs_s;

    dlr_regs_s q;
    dlr_regs_s d;

    // ************************************************************
    // decode helpers
    // ************************************************************
    // words after the header; zero for header-only or unknown types
    function automatic logic [7:0] dlr_words(input logic [31:0] hdr);
        logic [7:0] n;
        n = 8'h00;
        case (hdr[31:24])
            dlr_pkg::TY_PIXEL: n = dlr_pkg::WORDS_PIXEL;
            dlr_pkg::TY_DEPTH_PIXEL: n = dlr_pkg::WORDS_DEPTH_PIXEL;
            dlr_pkg::TY_LINE: n = dlr_pkg::WORDS_LINE;
            dlr_pkg::TY_XY_LINE: n = dlr_pkg::WORDS_XY_LINE;
            dlr_pkg::TY_PXY_LINE: n = dlr_pkg::WORDS_PACKED;
            dlr_pkg::TY_TRAP: n = dlr_pkg::WORDS_TRAP;
            dlr_pkg::TY_VTX: n = dlr_pkg::WORDS_VTX;
            dlr_pkg::TY_PVTX: n = dlr_pkg::WORDS_PACKED;
            dlr_pkg::TY_REG_LOAD: n = hdr[23:16];
            default: n = 8'h00;
        endcase
        return n;
    endfunction : dlr_words

    // vertex code legal for the shape: lines allow only 00 and 01
    function automatic logic dlr_vtx_ok(input logic [1:0] code, input logic is_line);
        return (code != dlr_pkg::VTX_CODE_BAD) && !(is_line && code == dlr_pkg::VTX_CODE_TRI);
    endfunction : dlr_vtx_ok

    function automatic logic [15:0] dlr_min(input logic [15:0] a, input logic [15:0] b);
        return ($signed(a) < $signed(b)) ? a : b;
    endfunction : dlr_min

    function automatic logic [15:0] dlr_max(input logic [15:0] a, input logic [15:0] b);
        return ($signed(a) > $signed(b)) ? a : b;
    endfunction : dlr_max

    logic take;
    logic vb_rise;
    logic addr_ok;
    logic is_draw_type;
    logic is_xy;
    logic last_word;
    assign take = dl_valid_i && q.ready;
    assign vb_rise = q.vb2 && !q.vb3;
    assign addr_ok = hsel_i && hready_i && htrans_i[1];
    assign is_draw_type = (q.typ <= dlr_pkg::TY_TRAP);
    assign is_xy = (q.typ == dlr_pkg::TY_XY_LINE) || (q.typ == dlr_pkg::TY_PXY_LINE);
    assign last_word = (q.idx + 8'h01) == q.cnt;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        d.reg_wr = 1'b0;
        d.prm_wr = 1'b0;
        d.vtx_wr = 1'b0;
        d.go = 1'b0;
        d.vb1 = vertical_blank_flag_i;
        d.vb2 = q.vb1;
        d.vb3 = q.vb2;

        // bus slave: address phase captured, write lands in data phase
        d.ahb_wr = addr_ok && hwrite_i;
        d.ahb_ofs = haddr_i[7:0];
        if (addr_ok && !hwrite_i) begin
            case (haddr_i[7:0])
                dlr_pkg::OFS_CTRL: d.rdata = {31'h0, q.run};
                dlr_pkg::OFS_STATUS: d.rdata = {28'h0, q.err_type, q.err_vtx, q.st == dlr_pkg::DLR_SYNC,
                                                q.st != dlr_pkg::DLR_FETCH};
                dlr_pkg::OFS_COUNT: d.rdata = {16'h0, q.cmds};
                default: d.rdata = 32'h0;
            endcase
        end
        if (q.ahb_wr && q.ahb_ofs == dlr_pkg::OFS_CTRL) begin
            d.run = hwdata_i[dlr_pkg::CTRL_RUN_BIT];
        end
        // write one clears; a new error in the same cycle is set below and wins
        if (q.ahb_wr && q.ahb_ofs == dlr_pkg::OFS_STATUS) begin
            if (hwdata_i[dlr_pkg::ST_ERR_VTX_BIT]) begin
                d.err_vtx = 1'b0;
            end
            if (hwdata_i[dlr_pkg::ST_ERR_TYPE_BIT]) begin
                d.err_type = 1'b0;
            end
        end

        case (q.st)
            dlr_pkg::DLR_FETCH: begin
                if (take) begin
                    // bits 15:2 only looked at as part of the TY_REG_LOAD start address in raddr
                    d.typ = dl_word_i[31:24];
                    d.sub = dl_word_i[23:16];
                    d.vsel = dl_word_i[1:0];
                    d.raddr = dl_word_i[15:0];
                    d.cnt = dlr_words(dl_word_i);
                    d.idx = 8'h00;
                    d.cmds = q.cmds + 16'h0001;
                    d.st = (dlr_words(dl_word_i) != 8'h00) ? dlr_pkg::DLR_PARAM : dlr_pkg::DLR_FETCH;
                    case (dl_word_i[31:24])
                        dlr_pkg::TY_SYNC: begin
                            if (dl_word_i[dlr_pkg::HDR_VERTICAL_BLANK_FLAG_BIT]) begin
                                d.st = dlr_pkg::DLR_SYNC;
                            end
                        end
                        dlr_pkg::TY_DRAW: begin
                            if (dl_word_i[23:16] == dlr_pkg::SUB_SHAPE_FILL
                                    || dl_word_i[23:16] == dlr_pkg::SUB_PIXEL_FLUSH
                                    || dl_word_i[23:16] == dlr_pkg::SUB_DEPTH_FLUSH) begin
                                d.st = dlr_pkg::DLR_DRAW;
                            end
                        end
                        dlr_pkg::TY_VTX, dlr_pkg::TY_PVTX: begin
                            if (dl_word_i[23:16] == dlr_pkg::SUB_SHAPE_START) begin
                                d.shape_on = 1'b1;
                                d.bb_valid = 1'b0;
                            end
                        end
                        dlr_pkg::TY_PIXEL, dlr_pkg::TY_DEPTH_PIXEL, dlr_pkg::TY_LINE, dlr_pkg::TY_XY_LINE,
                        dlr_pkg::TY_PXY_LINE, dlr_pkg::TY_TRAP, dlr_pkg::TY_REG_LOAD,
                        dlr_pkg::TY_NOP, dlr_pkg::TY_IRQ: begin
                        end
                        default: begin
                            // length of an unknown command cannot be known; skip the header only
                            d.err_type = 1'b1;
                        end
                    endcase
                end
            end
            dlr_pkg::DLR_PARAM: begin
                if (take) begin
                    d.idx = q.idx + 8'h01;
                    case (q.typ)
                        dlr_pkg::TY_REG_LOAD: begin
                            d.reg_wr = 1'b1;
                            d.reg_addr = q.raddr;
                            d.reg_data = dl_word_i;
                            d.raddr = q.raddr + 16'h0001;
                        end
                        dlr_pkg::TY_VTX: begin
                            if (q.idx == 8'h00) begin
                                d.vtx_x = dl_word_i[31:16];
                            end else begin
                                d.vtx_y = dl_word_i[31:16];
                                d.vtx_wr = dlr_vtx_ok(q.vsel, 1'b0);
                            end
                            d.vtx_sel = q.vsel;
                        end
                        dlr_pkg::TY_PVTX: begin
                            d.vtx_x = dl_word_i[15:0];
                            d.vtx_y = dl_word_i[31:16];
                            d.vtx_sel = q.vsel;
                            d.vtx_wr = dlr_vtx_ok(q.vsel, 1'b0);
                        end
                        default: begin
                            d.prm_wr = 1'b1;
                            d.prm_idx = q.idx[3:0];
                            // TY_XY_LINE fractional halves are dropped: integer coordinates only
                            d.prm_data = (q.typ == dlr_pkg::TY_XY_LINE) ? {dl_word_i[31:16], 16'h0000}
                                                                         : dl_word_i;
                        end
                    endcase
                    if ((q.typ == dlr_pkg::TY_VTX || q.typ == dlr_pkg::TY_PVTX) && last_word
                            && !dlr_vtx_ok(q.vsel, 1'b0)) begin
                        d.err_vtx = 1'b1;
                    end
                    if (last_word) begin
                        d.st = dlr_pkg::DLR_FETCH;
                        if (is_draw_type) begin
                            d.st = dlr_pkg::DLR_DRAW;
                        end
                        if (is_xy && !dlr_vtx_ok(q.vsel, 1'b1)) begin
                            d.err_vtx = 1'b1;
                            d.st = dlr_pkg::DLR_FETCH;
                        end
                    end
                end
            end
            dlr_pkg::DLR_SYNC: begin
                if (vb_rise) begin
                    d.st = dlr_pkg::DLR_FETCH;
                end
            end
            dlr_pkg::DLR_DRAW: begin
                // rasteriser still consumes the previous job's parameters
                if (!raster_busy_i) begin
                    d.go = 1'b1;
                    d.go_type = q.typ;
                    d.go_sub = q.sub;
                    d.go_line = q.sub[3:0];
                    d.go_left = q.sub[0];
                    d.st = dlr_pkg::DLR_FETCH;
                    if (q.typ == dlr_pkg::TY_DRAW && q.sub == dlr_pkg::SUB_SHAPE_FILL) begin
                        d.shape_on = 1'b0;
                    end
                end
            end
            default: begin
                d.st = dlr_pkg::DLR_FETCH;
            end
        endcase

        // grow the rectangle with the vertex being written this cycle
        if (d.vtx_wr && q.shape_on) begin
            d.bb_valid = 1'b1;
            d.bb_x0 = q.bb_valid ? dlr_min(q.bb_x0, d.vtx_x) : d.vtx_x;
            d.bb_y0 = q.bb_valid ? dlr_min(q.bb_y0, d.vtx_y) : d.vtx_y;
            d.bb_x1 = q.bb_valid ? dlr_max(q.bb_x1, d.vtx_x) : d.vtx_x;
            d.bb_y1 = q.bb_valid ? dlr_max(q.bb_y1, d.vtx_y) : d.vtx_y;
        end

        // registered ready follows the next state, so no word past the last is taken
        d.ready = d.run && (d.st == dlr_pkg::DLR_FETCH || d.st == dlr_pkg::DLR_PARAM);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.st <= dlr_pkg::DLR_FETCH;
            q.run <= dlr_pkg::RUN_RST;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign dl_ready_o = q.ready;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = q.rdata;
    assign reg_wr_o = q.reg_wr;
    assign reg_addr_o = q.reg_addr;
    assign reg_data_o = q.reg_data;
    assign prm_wr_o = q.prm_wr;
    assign prm_idx_o = q.prm_idx;
    assign prm_data_o = q.prm_data;
    assign vtx_wr_o = q.vtx_wr;
    assign vtx_sel_o = q.vtx_sel;
    assign vtx_x_o = q.vtx_x;
    assign vtx_y_o = q.vtx_y;
    assign bb_xmin_o = q.bb_x0;
    assign bb_ymin_o = q.bb_y0;
    assign bb_xmax_o = q.bb_x1;
    assign bb_ymax_o = q.bb_y1;
    assign draw_go_o = q.go;
    assign draw_type_o = q.go_type;
    assign draw_sub_o = q.go_sub;
    assign ln_alt_o = q.go_line[0];
    assign ln_no_end_o = q.go_line[1];
    assign ln_pat_clr_o = q.go_line[2];
    assign ln_anti_o = q.go_line[3];
    assign trap_left_o = q.go_left;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_ready_state;
        q.ready |-> (q.st == dlr_pkg::DLR_FETCH || q.st == dlr_pkg::DLR_PARAM);
    endproperty
    a_ready_state: assert property (p_ready_state) else $error("ready outside fetch or param");

    property p_sync_stall;
        q.st == dlr_pkg::DLR_SYNC |-> !q.ready && !q.go;
    endproperty
    a_sync_stall: assert property (p_sync_stall) else $error("stream moved during sync");

    property p_sync_release;
        (q.st == dlr_pkg::DLR_SYNC && vb_rise && clk_en_i) |=> q.st == dlr_pkg::DLR_FETCH;
    endproperty
    a_sync_release: assert property (p_sync_release) else $error("vertical_blank_flag did not release sync");

    property p_reg_incr;
        (q.reg_wr && clk_en_i) ##1 q.reg_wr |-> q.reg_addr == $past(q.reg_addr) + 16'h0001;
    endproperty
    a_reg_incr: assert property (p_reg_incr) else $error("register address not consecutive");

    property p_param_bound;
        q.st == dlr_pkg::DLR_PARAM |-> q.idx < q.cnt;
    endproperty
    a_param_bound: assert property (p_param_bound) else $error("word index past count");

    property p_vtx_code;
        q.vtx_wr |-> q.vtx_sel != dlr_pkg::VTX_CODE_BAD;
    endproperty
    a_vtx_code: assert property (p_vtx_code) else $error("vertex written with code 11");

    property p_bbox;
        (q.vtx_wr && q.shape_on) |-> q.bb_valid && $signed(q.bb_x0) <= $signed(q.vtx_x)
            && $signed(q.vtx_x) <= $signed(q.bb_x1) && $signed(q.bb_y0) <= $signed(q.vtx_y)
            && $signed(q.vtx_y) <= $signed(q.bb_y1);
    endproperty
    a_bbox: assert property (p_bbox) else $error("vertex outside bounding rectangle");

    property p_go_source;
        q.go |-> $past(q.st) == dlr_pkg::DLR_DRAW && !$past(raster_busy_i);
    endproperty
    a_go_source: assert property (p_go_source) else $error("draw start without draw state");

    property p_xy_mask;
        (q.prm_wr && q.typ == dlr_pkg::TY_XY_LINE) |-> q.prm_data[15:0] == 16'h0000;
    endproperty
    a_xy_mask: assert property (p_xy_mask) else $error("xy line lower half not zero");

endmodule : dlr_cmd_decoder
`default_nettype wire

// ---- sim/dlr_list_feeder.sv ----
`timescale 1ns/1ps
`default_nettype none
module dlr_list_feeder (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic dl_ready_i,
    output logic [31:0] dl_word_o,
    output logic dl_valid_o
);
    // ********
    // producer side of the display list
    // ********
    logic [31:0] fifo_q[$];

    task automatic put(input logic [31:0] w);
        fifo_q.push_back(w);
    endtask : put

    // words leave strictly in stored order
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dl_valid_o <= 1'b0;
            dl_word_o <= 32'h0;
        end else if (!dl_valid_o || dl_ready_i) begin
            if (fifo_q.size() > 0) begin
                dl_valid_o <= 1'b1;
                dl_word_o <= fifo_q.pop_front();
            end else begin
                // stale data is not left on the bus once the offer ends
                dl_valid_o <= 1'b0;
                dl_word_o <= ~dl_word_o;
            end
        end
    end
endmodule : dlr_list_feeder
`default_nettype wire

// ---- sim/tb_display_list_render_cmd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_display_list_render_cmd_decoder;
    // ********
    // wiring
    // ********
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, vertical_blank_flag_i = 1'b0, raster_busy_i = 1'b0;
    logic hsel_i = 1'b0, hwrite_i = 1'b0, hreadyout_o, hresp_o, dl_valid_i, dl_ready_o;
    logic [1:0] htrans_i = 2'h0, vtx_sel_o;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, dl_word_i, reg_data_o, prm_data_o;
    logic reg_wr_o, prm_wr_o, vtx_wr_o, draw_go_o, ln_alt_o, ln_no_end_o, ln_pat_clr_o, ln_anti_o, trap_left_o;
    logic [15:0] reg_addr_o, vtx_x_o, vtx_y_o, bb_xmin_o, bb_ymin_o, bb_xmax_o, bb_ymax_o, first_addr;
    logic [3:0] prm_idx_o;
    logic [7:0] draw_type_o, draw_sub_o;
    logic [31:0] r;
    int n_mismatch = 0, n_compared = 0, n_reg = 0, n_prm = 0, n_vtx = 0, n_go = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    dlr_list_feeder i_dlr_list_feeder (.ref_clk_i, .sys_rst_i, .dl_ready_i(dl_ready_o),
        .dl_word_o(dl_word_i), .dl_valid_o(dl_valid_i));
    dlr_cmd_decoder i_dlr_cmd_decoder (.ref_clk_i, .sys_rst_i, .clk_en_i(1'b1), .dl_word_i, .dl_valid_i,
        .dl_ready_o, .vertical_blank_flag_i, .raster_busy_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .reg_wr_o, .reg_addr_o,
        .reg_data_o, .prm_wr_o, .prm_idx_o, .prm_data_o, .vtx_wr_o, .vtx_sel_o, .vtx_x_o, .vtx_y_o,
        .bb_xmin_o, .bb_ymin_o, .bb_xmax_o, .bb_ymax_o, .draw_go_o, .draw_type_o, .draw_sub_o, .ln_alt_o,
        .ln_no_end_o, .ln_pat_clr_o, .ln_anti_o, .trap_left_o);

    // counted mid-cycle, where the registered pulses are settled and the bench never races them
    always @(negedge ref_clk_i) begin
        if (reg_wr_o === 1'b1 && n_reg == 0) first_addr = reg_addr_o;
        n_reg += (reg_wr_o === 1'b1);
        n_prm += (prm_wr_o === 1'b1);
        n_vtx += (vtx_wr_o === 1'b1);
        n_go += (draw_go_o === 1'b1);
    end

    // ********
    // helpers and scenarios
    // ********
    task automatic chk(input logic [127:0] g, input logic [127:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= wr;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
        chk(hresp_o, 1'b0);
    endtask : ahb

    task automatic push(input logic [31:0] w);
        i_dlr_list_feeder.put(w);
    endtask : push

    task automatic cmd(input logic [31:0] h, input int n, input logic [31:0] b);
        push(h);
        for (int i = 0; i < n; i++) push(b + i);
    endtask : cmd

    // returns once the job count has reached k, or after 400 cycles with chk counting a mismatch
    task automatic wait_go(input int k);
        repeat (400) if (n_go < k) @(posedge ref_clk_i);
        chk(n_go, k);
    endtask : wait_go

    task automatic t_reg_load;
        n_reg = 0;
        n_prm = 0;
        cmd(32'hF102_0100, 2, 32'hA0);
        cmd(32'h0000_0000, 2, 32'h5);
        wait_go(n_go + 1);
        chk({n_reg, first_addr, reg_addr_o, reg_data_o}, {32'd2, 16'h0100, 16'h0101, 32'hA1});
        chk({draw_type_o, n_prm, prm_idx_o, prm_data_o}, {8'h00, 32'd2, 4'h1, 32'h6});
    endtask : t_reg_load

    task automatic t_busy_depth;
        int g = n_go;
        raster_busy_i <= 1'b1;
        cmd(32'h0101_0000, 3, 32'h10);
        repeat (30) @(posedge ref_clk_i);
        chk(n_go, g);
        raster_busy_i <= 1'b0;
        wait_go(g + 1);
        chk({draw_type_o, draw_sub_o, prm_idx_o, prm_data_o}, {16'h0101, 4'h2, 32'h12});
    endtask : t_busy_depth

    task automatic t_lines;
        for (int s = 0; s < 16; s++) begin
            n_prm = 0;
            cmd({8'h02, 8'h20 | 8'(s), 16'h0}, 5, 32'h100);
            wait_go(n_go + 1);
            chk({ln_anti_o, ln_pat_clr_o, ln_no_end_o, ln_alt_o, n_prm}, {4'(s), 32'd5});
        end
        cmd(32'h0331_0000, 2, 32'h0004_ABCD);
        wait_go(n_go + 1);
        chk({prm_data_o, ln_alt_o}, {32'h0004_0000, 1'b1});
        cmd(32'h0430_0000, 1, 32'h0009_0003);
        wait_go(n_go + 1);
        chk({draw_type_o, prm_data_o, ln_alt_o}, {8'h04, 32'h0009_0003, 1'b0});
        for (int l = 0; l < 2; l++) begin
            cmd({8'h05, 8'h60 | 8'(l), 16'h0}, 9, 32'h200);
            wait_go(n_go + 1);
            chk({trap_left_o, prm_idx_o, prm_data_o}, {1'(l), 4'h8, 32'h208});
        end
    endtask : t_lines

    task automatic t_vertex;
        int v;
        cmd(32'h70FF_0001, 0, 0);
        cmd(32'h0005_0000, 0, 0);
        cmd(32'h0007_0000, 0, 0);
        cmd(32'h0000_0000, 2, 0);
        wait_go(n_go + 1);
        chk({vtx_sel_o, vtx_x_o, vtx_y_o}, {2'h1, 16'h5, 16'h7});
        cmd(32'h71FF_0000, 1, 32'h0009_0003);
        cmd(32'h0000_0000, 2, 0);
        wait_go(n_go + 1);
        chk({vtx_sel_o, vtx_x_o, vtx_y_o}, {2'h0, 16'h3, 16'h9});
        v = n_vtx;
        cmd(32'h70FF_0003, 2, 32'h0001_0000);
        cmd(32'hFD00_0000, 0, 0);
        cmd(32'h8000_0000, 0, 0);
        cmd(32'h0000_0000, 2, 0);
        wait_go(n_go + 1);
        ahb(1'b0, 32'h4, 32'h0);
        chk({n_vtx, r[3:2]}, {v, 2'h3});
        ahb(1'b1, 32'h4, 32'hC);
        ahb(1'b0, 32'h4, 32'h0);
        chk(r[3:0], 4'h0);
        cmd(32'h70E0_0000, 0, 0);
        cmd(32'h000A_0000, 0, 0);
        cmd(32'h0014_0000, 0, 0);
        cmd(32'h70FF_0001, 0, 0);
        cmd(32'h001E_0000, 0, 0);
        cmd(32'h0005_0000, 0, 0);
        cmd(32'h0000_0000, 2, 0);
        wait_go(n_go + 1);
        chk({bb_xmin_o, bb_ymin_o, bb_xmax_o, bb_ymax_o}, {16'hA, 16'h5, 16'h1E, 16'h14});
        for (int k = 0; k < 3; k++) begin
            cmd({16'hF0E1 - 16'(k == 1 ? 32 : (k == 2 ? 31 : 0)), 16'h0}, 0, 0);
            wait_go(n_go + 1);
            chk(draw_sub_o, k == 0 ? 8'hE1 : (k == 1 ? 8'hC1 : 8'hC2));
        end
    endtask : t_vertex

    task automatic t_sync;
        int g = n_go;
        cmd(32'hFC00_0001, 0, 0);
        cmd(32'h0000_0000, 2, 0);
        repeat (40) @(posedge ref_clk_i);
        ahb(1'b0, 32'h4, 32'h0);
        chk({n_go, r[1]}, {g, 1'b1});
        vertical_blank_flag_i <= 1'b1;
        wait_go(g + 1);
        vertical_blank_flag_i <= 1'b0;
    endtask : t_sync

    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    initial begin
        repeat (12) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        ahb(1'b1, 32'h0, 32'h1);
        ahb(1'b0, 32'h0, 32'h0);
        chk(r, 32'h1);
        ahb(1'b0, 32'hC, 32'h0);
        chk(r, 32'h0);
        t_reg_load();
        t_busy_depth();
        t_lines();
        t_vertex();
        t_sync();
        conclude();
    end

    initial begin
        #2_000_000;
        n_mismatch++;
        conclude();
    end
endmodule : tb_display_list_render_cmd_decoder
`default_nettype wire
